// File: inc/loc_pkg.sv
// Package for the LED open check and identification register block.
// Assumes a single 250 MHz clock domain and an I2C-compatible register port.
`default_nettype none

package loc_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] LOC_OFF_TRIP_LEVEL = 8'h30; // proximity_trip_level
  localparam logic [7:0] LOC_OFF_CONTROL    = 8'h31; // led_open_check_control
  localparam logic [7:0] LOC_OFF_RESULT     = 8'h32; // led_open_check_result
  localparam logic [7:0] LOC_OFF_REVISION   = 8'hfe; // silicon_revision
  localparam logic [7:0] LOC_OFF_IDENT      = 8'hff; // device_identifier

  // ==========================================================================
  // Field layout and reset values
  localparam int         LOC_CTRL_COMP_BIT  = 0;     // Comparator enable
  localparam int         LOC_CTRL_FORCE_LSB = 4;     // force_drive_one..four at 7:4
  localparam int         LOC_NUM_LED        = 4;
  localparam logic [7:0] LOC_CTRL_WMASK     = 8'hf1; // Writable control bits
  localparam logic [7:0] LOC_TRIP_RESET     = 8'h00;
  localparam logic [7:0] LOC_CTRL_RESET     = 8'h00;
  localparam logic [3:0] LOC_RESULT_RESET   = 4'h0;
  localparam logic [7:0] LOC_TRIP_MAX       = 8'hff; // Only saturation trips

  // ==========================================================================
  // ADC layout: trip level is the top eight bits of a 19-bit count
  localparam int          LOC_ADC_W   = 19;
  localparam int          LOC_ADC_MSB = 18;
  localparam int          LOC_ADC_LSB = 11;
  localparam logic [18:0] LOC_ADC_SAT = 19'h7ffff;

  // ==========================================================================
  // Serial port
  localparam logic [6:0] LOC_I2C_ADDR_DEF = 7'h5a; // Arbitrary default
  localparam logic [3:0] LOC_BITS_BYTE    = 4'h8;
  localparam logic [2:0] LOC_LAST_TX_BIT  = 3'h7;

  typedef enum logic [3:0] {
    LOC_ST_IDLE,
    LOC_ST_ADDR,
    LOC_ST_ACK_ADDR,
    LOC_ST_PTR,
    LOC_ST_ACK_PTR,
    LOC_ST_WDATA,
    LOC_ST_ACK_WDATA,
    LOC_ST_RDATA,
    LOC_ST_RACK
  } loc_i2c_state_t;

endpackage : loc_pkg

`default_nettype wire

// File: inc/loc_core_if.sv
// Interface between the register front end and the proximity/open-check core.
// Assumes both ends share sys_clk; all signals are same-domain.
`default_nettype none

interface loc_core_if;
  import loc_pkg::*;

  logic [7:0]           trip_level;    // Proximity threshold register
  logic                 comp_en;       // Comparator enable bit
  logic [3:0]           force_req;     // Forced-on test bits, LED four..one at 3:0
  logic                 adc_valid;     // New first-channel sample
  logic [LOC_ADC_W-1:0] adc_count;     // First-channel ADC count
  logic                 near_object_event_mode;     // Proximity mode active
  logic [3:0]           open_sync;     // Synchronised comparator outputs
  logic                 near_event;    // Proximity trip pulse
  logic                 go_normal;     // Leave proximity mode pulse
  logic [3:0]           force_drive;   // Driver force-on, gated
  logic [3:0]           open_flags;    // Captured open-circuit flags

  modport front (output trip_level, comp_en, force_req, adc_valid, adc_count, near_object_event_mode,
                 open_sync, input near_event, go_normal, force_drive, open_flags);
  modport core  (input trip_level, comp_en, force_req, adc_valid, adc_count, near_object_event_mode,
                 open_sync, output near_event, go_normal, force_drive, open_flags);
endinterface : loc_core_if

`default_nettype wire

// File: hdl/loc_core.sv
// Proximity threshold compare and LED open-circuit test core.
// Assumes inputs on the interface are already in the sys_clk domain.
`default_nettype none

module loc_core
  import loc_pkg::*;
(
  input  wire logic   sys_clk,
  input  wire logic   rst_n,
  loc_core_if.core    cif
);

  // ==========================================================================
  // Proximity compare
  logic [7:0] adc_top;
  logic       trip_hit;

  assign adc_top  = cif.adc_count[LOC_ADC_MSB:LOC_ADC_LSB];
  // Top code means saturation only, else top byte at or above level
  assign trip_hit = (cif.trip_level == LOC_TRIP_MAX) ?
                    (cif.adc_count == LOC_ADC_SAT) :
                    (adc_top >= cif.trip_level);

  // Event and mode-change pulses, only while proximity mode runs
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cif.near_event <= 1'b0;
      cif.go_normal  <= 1'b0;
    end else begin
      cif.near_event <= cif.adc_valid & cif.near_object_event_mode & trip_hit;
      cif.go_normal  <= cif.adc_valid & cif.near_object_event_mode & trip_hit;
    end
  end

  // ==========================================================================
  // Per-driver force and result capture
  genvar g;
  generate
    for (g = 0; g < LOC_NUM_LED; g++) begin : g_led
      // Force only while comparator is enabled
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          cif.force_drive[g] <= 1'b0;
        end else begin
          cif.force_drive[g] <= cif.comp_en & cif.force_req[g];
        end
      end
      // Flag tracks comparator while enabled, holds last result when off
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          cif.open_flags[g] <= LOC_RESULT_RESET[g];
        end else if (cif.comp_en) begin
          cif.open_flags[g] <= cif.open_sync[g];
        end
      end
    end
  endgenerate

endmodule : loc_core

`default_nettype wire

// File: hdl/loc_top.sv
// LED open check, proximity threshold and identification registers with
// an I2C-compatible slave port.
// Assumes scl/sda and comparator outputs are asynchronous pins; the ADC
// sample, its strobe and the proximity-mode flag come from sys_clk logic.
`default_nettype none

module loc_top
  import loc_pkg::*;
#(
  parameter logic [6:0] I2C_ADDR      = LOC_I2C_ADDR_DEF,
  parameter logic [7:0] REVISION_CODE = 8'h01,  // Arbitrary value
  parameter logic [7:0] IDENT_CODE    = 8'h5c   // Arbitrary value
)(
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire logic                 scl_i,
  input  wire logic                 sda_i,
  output var  logic                 sda_o,
  output var  logic                 sda_oe,
  input  wire logic                 adc_valid,
  input  wire logic [LOC_ADC_W-1:0] adc_count,
  input  wire logic                 near_object_event_mode,
  input  wire logic [3:0]           open_raw,
  output var  logic                 comp_enable,
  output wire logic [3:0]           force_drive,
  output wire logic [3:0]           open_flags,
  output wire logic                 near_object_event,
  output wire logic                 go_normal_mode
);

  // ==========================================================================
  // Pin synchronisers
  logic [1:0] scl_s_r;
  logic [1:0] sda_s_r;
  logic       scl_d_r;
  logic       sda_d_r;
  logic [3:0] open_m_r;
  logic [3:0] open_s_r;

  // Two flops before any logic; third stage only for edge detection
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s_r  <= 2'h3;
      sda_s_r  <= 2'h3;
      scl_d_r  <= 1'b1;
      sda_d_r  <= 1'b1;
      open_m_r <= 4'h0;
      open_s_r <= 4'h0;
    end else begin
      scl_s_r  <= {scl_s_r[0], scl_i};
      sda_s_r  <= {sda_s_r[0], sda_i};
      scl_d_r  <= scl_s_r[1];
      sda_d_r  <= sda_s_r[1];
      open_m_r <= open_raw;
      open_s_r <= open_m_r;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  assign scl_rise   = scl_s_r[1] & ~scl_d_r;
  assign scl_fall   = ~scl_s_r[1] & scl_d_r;
  assign start_cond = scl_s_r[1] & scl_d_r & sda_d_r & ~sda_s_r[1];
  assign stop_cond  = scl_s_r[1] & scl_d_r & ~sda_d_r & sda_s_r[1];

  // ==========================================================================
  // Registers
  logic [7:0] trip_level_r;
  logic [7:0] control_r;
  logic [7:0] ptr_r;
  logic [7:0] rd_data;
  logic       wr_pulse;
  logic [7:0] rx_sh_r;

  // Bundle toward the core, declared ahead of the read mux that uses it
  loc_core_if cif ();

  // Read mux; offsets outside this block read zero
  always_comb begin
    unique case (ptr_r)
      LOC_OFF_TRIP_LEVEL: rd_data = trip_level_r;
      LOC_OFF_CONTROL:    rd_data = control_r & LOC_CTRL_WMASK;
      LOC_OFF_RESULT:     rd_data = {4'h0, cif.open_flags};
      LOC_OFF_REVISION:   rd_data = REVISION_CODE;
      LOC_OFF_IDENT:      rd_data = IDENT_CODE;
      default:            rd_data = 8'h00;
    endcase
  end

  // Writable registers; read-only offsets simply drop the write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trip_level_r <= LOC_TRIP_RESET;
      control_r    <= LOC_CTRL_RESET;
    end else if (wr_pulse) begin
      if (ptr_r == LOC_OFF_TRIP_LEVEL) begin
        trip_level_r <= rx_sh_r;
      end
      if (ptr_r == LOC_OFF_CONTROL) begin
        control_r <= rx_sh_r & LOC_CTRL_WMASK;
      end
    end
  end

  // Comparator enable straight from the control register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      comp_enable <= 1'b0;
    end else begin
      comp_enable <= control_r[LOC_CTRL_COMP_BIT];
    end
  end

  // ==========================================================================
  // Serial slave
  loc_i2c_state_t state_r;
  logic [3:0]     bitcnt_r;
  logic [7:0]     tx_sh_r;
  logic           is_read_r;
  logic           nack_r;

  assign wr_pulse = (state_r == LOC_ST_ACK_WDATA) & scl_fall;

  // Byte-level protocol; pointer auto-increments on each data byte
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= LOC_ST_IDLE;
      bitcnt_r  <= 4'h0;
      rx_sh_r   <= 8'h00;
      tx_sh_r   <= 8'h00;
      is_read_r <= 1'b0;
      nack_r    <= 1'b0;
      ptr_r     <= 8'h00;
      sda_oe    <= 1'b0;
    end else if (start_cond) begin
      state_r  <= LOC_ST_ADDR;
      bitcnt_r <= 4'h0;
      sda_oe   <= 1'b0;
    end else if (stop_cond) begin
      state_r <= LOC_ST_IDLE;
      sda_oe  <= 1'b0;
    end else begin
      unique case (state_r)
        LOC_ST_IDLE: begin
          sda_oe <= 1'b0;
        end
        LOC_ST_ADDR, LOC_ST_PTR, LOC_ST_WDATA: begin
          if (scl_rise && bitcnt_r < LOC_BITS_BYTE) begin
            rx_sh_r  <= {rx_sh_r[6:0], sda_s_r[1]};
            bitcnt_r <= bitcnt_r + 4'h1;
          end else if (scl_fall && bitcnt_r == LOC_BITS_BYTE) begin
            bitcnt_r <= 4'h0;
            if (state_r == LOC_ST_ADDR) begin
              // Foreign address: stay off the bus until next start
              if (rx_sh_r[7:1] == I2C_ADDR) begin
                is_read_r <= rx_sh_r[0];
                sda_oe    <= 1'b1;
                state_r   <= LOC_ST_ACK_ADDR;
              end else begin
                state_r <= LOC_ST_IDLE;
              end
            end else begin
              sda_oe  <= 1'b1;
              state_r <= (state_r == LOC_ST_PTR) ? LOC_ST_ACK_PTR : LOC_ST_ACK_WDATA;
            end
          end
        end
        LOC_ST_ACK_ADDR: begin
          if (scl_fall) begin
            if (is_read_r) begin
              tx_sh_r <= rd_data;
              sda_oe  <= ~rd_data[7];
              ptr_r   <= ptr_r + 8'h01;
              state_r <= LOC_ST_RDATA;
            end else begin
              sda_oe  <= 1'b0;
              state_r <= LOC_ST_PTR;
            end
          end
        end
        LOC_ST_ACK_PTR: begin
          if (scl_fall) begin
            ptr_r   <= rx_sh_r;
            sda_oe  <= 1'b0;
            state_r <= LOC_ST_WDATA;
          end
        end
        LOC_ST_ACK_WDATA: begin
          if (scl_fall) begin
            ptr_r   <= ptr_r + 8'h01; // Write lands this same edge
            sda_oe  <= 1'b0;
            state_r <= LOC_ST_WDATA;
          end
        end
        LOC_ST_RDATA: begin
          if (scl_fall) begin
            if (bitcnt_r[2:0] == LOC_LAST_TX_BIT) begin
              bitcnt_r <= 4'h0;
              sda_oe   <= 1'b0;
              state_r  <= LOC_ST_RACK;
            end else begin
              tx_sh_r  <= {tx_sh_r[6:0], 1'b0};
              sda_oe   <= ~tx_sh_r[6];
              bitcnt_r <= bitcnt_r + 4'h1;
            end
          end
        end
        LOC_ST_RACK: begin
          if (scl_rise) begin
            nack_r <= sda_s_r[1];
          end else if (scl_fall) begin
            // Master nack ends the read burst
            if (nack_r) begin
              state_r <= LOC_ST_IDLE;
            end else begin
              tx_sh_r <= rd_data;
              sda_oe  <= ~rd_data[7];
              ptr_r   <= ptr_r + 8'h01;
              state_r <= LOC_ST_RDATA;
            end
          end
        end
        default: begin
          state_r <= LOC_ST_IDLE;
        end
      endcase
    end
  end

  // Open drain: data line only ever pulled low
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  // ==========================================================================
  // Core
  assign cif.trip_level = trip_level_r;
  assign cif.comp_en    = control_r[LOC_CTRL_COMP_BIT];
  assign cif.force_req  = control_r[LOC_CTRL_FORCE_LSB +: LOC_NUM_LED];
  assign cif.adc_valid  = adc_valid;
  assign cif.adc_count  = adc_count;
  assign cif.near_object_event_mode  = near_object_event_mode;
  assign cif.open_sync  = open_s_r;

  loc_core u_core (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .cif     (cif.core)
  );

  // Core outputs are flops inside the core
  assign force_drive       = cif.force_drive;
  assign open_flags        = cif.open_flags;
  assign near_object_event = cif.near_event;
  assign go_normal_mode    = cif.go_normal;

endmodule : loc_top

`default_nettype wire

// File: dv/loc_top_properties.sv
// Port-level properties of the LED open check block.
// Assumes binding into loc_top; one sys_clk domain, rst_n active low.
`default_nettype none

module loc_top_properties
  import loc_pkg::*;
(
  input wire logic                 sys_clk,
  input wire logic                 rst_n,
  input wire logic                 scl_i,
  input wire logic                 sda_o,
  input wire logic                 sda_oe,
  input wire logic                 adc_valid,
  input wire logic [LOC_ADC_W-1:0] adc_count,
  input wire logic                 near_object_event_mode,
  input wire logic [3:0]           open_raw,
  input wire logic                 comp_enable,
  input wire logic [3:0]           force_drive,
  input wire logic [3:0]           open_flags,
  input wire logic                 near_object_event,
  input wire logic                 go_normal_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================================
  // Proximity trip
  a_trip_cause: assert property (
    near_object_event |-> $past(adc_valid) && $past(near_object_event_mode))
    else $error("trip without sample");
  a_trip_pair: assert property (
    near_object_event == go_normal_mode) else $error("mode pulse apart from trip");
  a_sat_trips: assert property (
    adc_valid && near_object_event_mode && adc_count == LOC_ADC_SAT |=> near_object_event)
    else $error("saturated sample missed");

  // ==========================================================================
  // Open check: drivers only forced while the comparator runs
  a_force_gate: assert property (
    force_drive != 4'h0 |-> comp_enable) else $error("driver forced while off");
  a_flags_follow: assert property (
    comp_enable [*5] |-> open_flags == $past(open_raw, 3)) else $error("flag lost");
  a_flags_hold: assert property (
    !comp_enable [*5] |-> $stable(open_flags)) else $error("flag moved while off");

  // ==========================================================================
  // Open-drain port: data only pulled, and only changed while the clock is low
  a_sda_pull: assert property (sda_o == 1'b0) else $error("data line driven high");
  a_oe_scl_low: assert property (
    $changed(sda_oe) |-> !scl_i) else $error("data moved with clock high");
endmodule : loc_top_properties

bind loc_top loc_top_properties i_loc_top_properties (
  .sys_clk, .rst_n, .scl_i, .sda_o, .sda_oe, .adc_valid, .adc_count, .near_object_event_mode,
  .open_raw, .comp_enable, .force_drive, .open_flags, .near_object_event, .go_normal_mode
);

`default_nettype wire

// File: dv/loc_i2c_host.sv
// Host controller model: bit-banged master of the serial register port.
// Assumes a pulled-up open-drain data line; paced by sys_clk edges.
`default_nettype none

module loc_i2c_host
  import loc_pkg::*;
#(
  parameter logic [6:0] ADDR = LOC_I2C_ADDR_DEF
)(
  input  wire logic sys_clk,
  input  wire logic sda_oe,
  output wire logic scl,
  output wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl_r = 1'b1;
  logic low_r = 1'b0;

  // Wired-AND over the pull-up, so a released line reads high
  assign scl = scl_r;
  assign sda = !(low_r || sda_oe);

  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wt

  // Phases of 6 cycles keep scl well above the 4-cycle minimum
  task automatic put_bit(input logic b, output logic got);
    low_r <= !b;
    wt(6);
    scl_r <= 1'b1;
    wt(6);
    got = sda;
    scl_r <= 1'b0;
    wt(6);
  endtask : put_bit

  // Start or repeated start
  task automatic start();
    low_r <= 1'b0;
    wt(6);
    scl_r <= 1'b1;
    wt(6);
    low_r <= 1'b1;
    wt(6);
    scl_r <= 1'b0;
    wt(6);
  endtask : start

  task automatic stop();
    low_r <= 1'b1;
    wt(6);
    scl_r <= 1'b1;
    wt(6);
    low_r <= 1'b0;
    wt(6);
  endtask : stop

  // Byte out, byte in; ninth bit released (nack on reads)
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      put_bit(tx[i], g);
      rx[i] = g;
    end
    put_bit(1'b1, g);
    ack = !g;
  endtask : xfer

  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    logic [7:0] r;
    logic a;
    start();
    xfer({ADDR, 1'b0}, r, a);
    xfer(ptr, r, a);
    xfer(d, r, a);
    stop();
  endtask : wr

  task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
    logic [7:0] r;
    logic a;
    start();
    xfer({ADDR, 1'b0}, r, a);
    xfer(ptr, r, a);
    start();
    xfer({ADDR, 1'b1}, r, a);
    xfer(8'hff, d, a);
    stop();
  endtask : rd
endmodule : loc_i2c_host

`default_nettype wire

// File: dv/loc_top_tb_top.sv
// Self-checking bench: registers through the host model, sensor pins direct.
// Assumes loc_pkg, loc_i2c_host and the bound checker are compiled first.
`default_nettype none

module loc_top_tb_top
  import loc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] REV_CODE = 8'h3c; // Arbitrary value
  localparam logic [7:0] ID_CODE  = 8'h96; // Arbitrary value
  logic        sys_clk   = 1'b0;
  logic        rst_n     = 1'b0;
  logic        adc_valid = 1'b0;
  logic [18:0] adc_count = 19'h00000;
  logic        near_object_event_mode = 1'b0;
  logic [3:0]  open_raw  = 4'h0;
  wire logic   scl, sda, sda_oe;
  logic        comp_enable, near_object_event, go_normal_mode;
  logic [3:0]  force_drive, open_flags;
  logic [7:0]  rd_val, junk;
  logic        ack;
  int          num_errors = 0;
  int          check_count = 0;
  int          cycles = 0;

  loc_top #(.REVISION_CODE(REV_CODE), .IDENT_CODE(ID_CODE)) i_loc_top (
    .sys_clk, .rst_n, .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe, .adc_valid, .adc_count,
    .near_object_event_mode, .open_raw, .comp_enable, .force_drive, .open_flags, .near_object_event,
    .go_normal_mode
  );
  loc_i2c_host i_loc_i2c_host (.sys_clk, .sda_oe, .scl, .sda);

  // ==========================================================================
  // Clock, timeout and checking helpers
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  // Whole run needs about 20k cycles; three times that means a hang
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      conclude();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rchk(input logic [7:0] ptr, input logic [7:0] exp);
    i_loc_i2c_host.rd(ptr, rd_val);
    chk(rd_val, exp);
  endtask : rchk

  // One sample; trip must show within three cycles
  task automatic samp(input logic [18:0] cnt, input logic mode, input logic exp);
    logic seen;
    seen = 1'b0;
    @(posedge sys_clk);
    adc_count <= cnt;
    near_object_event_mode <= mode;
    adc_valid <= 1'b1;
    @(posedge sys_clk);
    adc_valid <= 1'b0;
    repeat (3) begin
      @(posedge sys_clk);
      seen = seen | (near_object_event & go_normal_mode);
    end
    chk({7'h00, seen}, {7'h00, exp});
  endtask : samp

  // ==========================================================================
  // Scenarios
  task automatic t_regs();
    rchk(LOC_OFF_TRIP_LEVEL, 8'h00);
    rchk(LOC_OFF_CONTROL, 8'h00);
    rchk(LOC_OFF_RESULT, 8'h00);
    rchk(LOC_OFF_REVISION, REV_CODE);
    rchk(LOC_OFF_IDENT, ID_CODE);
    i_loc_i2c_host.wr(LOC_OFF_TRIP_LEVEL, 8'ha5);
    rchk(LOC_OFF_TRIP_LEVEL, 8'ha5);
    i_loc_i2c_host.wr(LOC_OFF_CONTROL, 8'hfe);
    chk({7'h00, comp_enable}, 8'h00);
    chk({4'h0, force_drive}, 8'h00);
    rchk(LOC_OFF_CONTROL, 8'hf0);
    i_loc_i2c_host.wr(LOC_OFF_RESULT, 8'hff);
    i_loc_i2c_host.wr(LOC_OFF_REVISION, ~REV_CODE);
    i_loc_i2c_host.wr(LOC_OFF_IDENT, ~ID_CODE);
    rchk(LOC_OFF_RESULT, 8'h00);
    rchk(LOC_OFF_REVISION, REV_CODE);
    rchk(LOC_OFF_IDENT, ID_CODE);
    rchk(8'h40, 8'h00);
    i_loc_i2c_host.start();
    i_loc_i2c_host.xfer({LOC_I2C_ADDR_DEF ^ 7'h01, 1'b0}, junk, ack);
    i_loc_i2c_host.stop();
    chk({7'h00, ack}, 8'h00);
  endtask : t_regs

  // Host forces one driver at a time
  task automatic t_force();
    for (int i = 0; i < 4; i++) begin
      i_loc_i2c_host.wr(LOC_OFF_CONTROL, 8'h01 | (8'h10 << i));
      chk({4'h0, force_drive}, 8'h01 << i);
      chk({7'h00, comp_enable}, 8'h01);
    end
    i_loc_i2c_host.wr(LOC_OFF_CONTROL, 8'hff);
    rchk(LOC_OFF_CONTROL, 8'hf1);
  endtask : t_force

  task automatic t_open();
    i_loc_i2c_host.wr(LOC_OFF_CONTROL, 8'h01);
    open_raw <= 4'h5;
    i_loc_i2c_host.wt(6);
    chk({4'h0, open_flags}, 8'h05);
    rchk(LOC_OFF_RESULT, 8'h05);
    i_loc_i2c_host.wr(LOC_OFF_CONTROL, 8'h00);
    open_raw <= 4'ha;
    i_loc_i2c_host.wt(6);
    rchk(LOC_OFF_RESULT, 8'h05);
  endtask : t_open

  task automatic t_near_object_event();
    i_loc_i2c_host.wr(LOC_OFF_TRIP_LEVEL, 8'h01);
    samp(19'd2048, 1'b1, 1'b1);
    samp(19'd2047, 1'b1, 1'b0);
    samp(19'd2048, 1'b0, 1'b0);
    i_loc_i2c_host.wr(LOC_OFF_TRIP_LEVEL, LOC_TRIP_MAX);
    samp(19'h7fffe, 1'b1, 1'b0);
    samp(LOC_ADC_SAT, 1'b1, 1'b1);
    i_loc_i2c_host.wr(LOC_OFF_TRIP_LEVEL, 8'h00);
    samp(19'h00000, 1'b1, 1'b1);
  endtask : t_near_object_event

  // Two-byte read burst: master acks the first byte, pointer steps on
  task automatic t_burst();
    logic [7:0] b0;
    logic       g;
    i_loc_i2c_host.wr(LOC_OFF_TRIP_LEVEL, 8'h6e);
    i_loc_i2c_host.wr(LOC_OFF_CONTROL, 8'h11);
    i_loc_i2c_host.start();
    i_loc_i2c_host.xfer({LOC_I2C_ADDR_DEF, 1'b0}, junk, ack);
    i_loc_i2c_host.xfer(LOC_OFF_TRIP_LEVEL, junk, ack);
    i_loc_i2c_host.start();
    i_loc_i2c_host.xfer({LOC_I2C_ADDR_DEF, 1'b1}, junk, ack);
    for (int i = 7; i >= 0; i--) begin
      i_loc_i2c_host.put_bit(1'b1, g);
      b0[i] = g;
    end
    i_loc_i2c_host.put_bit(1'b0, g);
    i_loc_i2c_host.xfer(8'hff, rd_val, ack);
    i_loc_i2c_host.stop();
    chk(b0, 8'h6e);
    chk(rd_val, 8'h11);
  endtask : t_burst

  task automatic conclude();
    if (num_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    t_regs();
    t_force();
    t_open();
    t_near_object_event();
    t_burst();
    conclude();
  end
endmodule : loc_top_tb_top

`default_nettype wire
